// [verilog/dcc_pkg.sv]
// Constants, field layouts and types for the DMA channel control block
package dcc_pkg;

  // Register byte addresses
  localparam logic [31:0] CH10_CTL1_ADDR = 32'h100028ac;
  localparam logic [31:0] CH11_SRC_ADDR = 32'h100028b0;
  localparam logic [31:0] CH11_DST_ADDR = 32'h100028b4;
  localparam logic [31:0] CH11_CTL0_ADDR = 32'h100028b8;
  localparam logic [31:0] CH11_CTL1_ADDR = 32'h100028bc;
  localparam logic [31:0] CH12_SRC_ADDR = 32'h100028c0;
  localparam logic [31:0] CH12_DST_ADDR = 32'h100028c4;
  localparam logic [31:0] CH12_CTL0_ADDR = 32'h100028c8;
  localparam logic [31:0] CH12_CTL1_ADDR = 32'h100028cc;

  // Decode codes: bit 2 channel, bits 1:0 register within channel
  localparam logic [3:0] CODE_SRC = 4'h0;
  localparam logic [3:0] CODE_DST = 4'h1;
  localparam logic [3:0] CODE_CTL0 = 4'h2;
  localparam logic [3:0] CODE_CTL1 = 4'h3;
  localparam logic [3:0] CODE_CH12 = 4'h4;
  localparam logic [3:0] CODE_CH10_CTL1 = 4'h8;
  localparam logic [3:0] CODE_NONE = 4'hf;

  localparam logic [31:0] REG_RESET = 32'h00000000;
  // Writable bits; segment index and reserved bits excluded
  localparam logic [31:0] CTL0_WMASK = 32'hffff00ff;
  localparam logic [31:0] CTL1_WMASK = 32'h03ff7fff;

  localparam int NCH = 2;
  localparam logic [4:0] CH_NUM_10 = 5'h0a;
  localparam logic [4:0] CH_NUM_11 = 5'h0b;
  localparam logic [4:0] CH_NUM_12 = 5'h0c;

  localparam logic [5:0] MEM_SELECT = 6'h20;
  localparam logic [5:0] NUM_REQ_LINES = 6'h03;
  localparam logic [3:0] MAX_SEGMENT_ORDER = 4'h8;
  localparam logic [2:0] MAX_BURST_CODE = 3'h4;
  localparam logic [16:0] BEAT_BYTES = 17'h00004;
  localparam logic [31:0] BEAT_ADDR_STEP = 32'h00000004;

  typedef struct packed {
    logic [15:0] transfer_length_bytes;
    logic [7:0] segment_index;
    logic src_pointer_fixed;
    logic dst_pointer_fixed;
    logic [2:0] burst_code;
    logic segment_irq_enable;
    logic channel_run;
    logic software_trigger_mode;
  } dcc_ctl0_s;

  typedef struct packed {
    logic [5:0] reserved_hi;
    logic [3:0] segment_order;
    logic [5:0] src_request_select;
    logic reserved_mid;
    logic continuous_run_mode;
    logic [5:0] dst_request_select;
    logic [4:0] chained_channel_select;
    logic coherent_flush_enable;
    logic chain_release_error_irq_enable;
    logic channel_hold;
  } dcc_ctl1_s;

  typedef struct packed {
    logic write;
    logic [31:0] addr;
    logic [31:0] wdata;
  } dcc_mem_req_s;

  typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_WRITE, ST_FLUSH} dcc_state_e;

endpackage : dcc_pkg

// [verilog/dcc_channel_control.sv]
// DMA channel control: registers, request selection, segment and chain logic
`timescale 1ns/1ps

// Behaviour
// - Source pointer steps unless source fixed
// - Destination pointer steps unless destination fixed
// - Burst code selects 1 to 16 words
// - Segment end pulses irq when enabled
// - Run cleared at target without continuous
// - Continuous mode keeps run set
// - Software mode starts on run without waiting for a request line
// - Hardware mode waits selected request line
// - Segment order N up to 8 gives 2^N segments
// - Segment size is rounded-up quotient
// - Source select picks line or memory
// - Destination select picks line or memory
// - Completion clears chained channel hold bit
// - Coherent mode adds final dummy read
// - Hold already clear raises chain error
// - Hold bit blocks channel transfers
// - Upper control half holds byte target
// - Read-only field shows current segment
module dcc_channel_control
  import dcc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic peripheral_request_zero,
  input wire logic peripheral_request_one,
  input wire logic peripheral_request_two,
  output logic mem_valid,
  output dcc_mem_req_s mem_req,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  output logic [1:0] segment_done_irq,
  output logic [1:0] chain_error_irq
);

  function automatic logic [3:0] dcc_decode(input logic [31:0] a);
    case (a)
      CH11_SRC_ADDR: dcc_decode = CODE_SRC;
      CH11_DST_ADDR: dcc_decode = CODE_DST;
      CH11_CTL0_ADDR: dcc_decode = CODE_CTL0;
      CH11_CTL1_ADDR: dcc_decode = CODE_CTL1;
      CH12_SRC_ADDR: dcc_decode = CODE_CH12 | CODE_SRC;
      CH12_DST_ADDR: dcc_decode = CODE_CH12 | CODE_DST;
      CH12_CTL0_ADDR: dcc_decode = CODE_CH12 | CODE_CTL0;
      CH12_CTL1_ADDR: dcc_decode = CODE_CH12 | CODE_CTL1;
      CH10_CTL1_ADDR: dcc_decode = CODE_CH10_CTL1;
      default: dcc_decode = CODE_NONE;
    endcase
  endfunction : dcc_decode

  // Memory is always ready; unlisted select values never are
  function automatic logic line_ready(input logic [5:0] sel, input logic [2:0] lines);
    if (sel == MEM_SELECT) begin
      line_ready = 1'b1;
    end else if (sel < NUM_REQ_LINES) begin
      line_ready = lines[sel[1:0]];
    end else begin
      line_ready = 1'b0;
    end
  endfunction : line_ready

  // Undefined codes fall back to single words
  function automatic logic [4:0] burst_beats(input logic [2:0] code);
    burst_beats = (code > MAX_BURST_CODE) ? 5'h01 : (5'h01 << code);
  endfunction : burst_beats

  function automatic logic [15:0] seg_size_f(input logic [15:0] len, input logic [3:0] n);
    logic [3:0] k;
    logic [15:0] rem;
    k = (n > MAX_SEGMENT_ORDER) ? 4'h0 : n;
    rem = len & ((16'h0001 << k) - 16'h0001);
    seg_size_f = (len >> k) + {15'h0000, |rem};
  endfunction : seg_size_f

  logic [31:0] src_reg [NCH];
  logic [31:0] dst_reg [NCH];
  dcc_ctl0_s ctl0 [NCH];
  dcc_ctl1_s ctl1 [NCH];
  dcc_ctl1_s ch10_ctl1;
  dcc_ctl0_s next_ctl0 [NCH];
  dcc_ctl1_s next_ctl1 [NCH];
  dcc_ctl1_s next_ch10_ctl1;

  logic [2:0] req_meta;
  logic [2:0] req_sync;

  dcc_state_e state;
  logic cur;
  logic [4:0] beat;
  logic [31:0] src_cur [NCH];
  logic [31:0] dst_cur [NCH];
  logic [16:0] done_bytes [NCH];
  logic [16:0] seg_bytes [NCH];
  logic [NCH-1:0] fresh;

  // Bus decode
  wire [3:0] reg_code = dcc_decode(paddr);
  wire apb_setup_ok = psel & penable & ~pready;
  wire wr_en = psel & penable & pready & pwrite & (reg_code != CODE_NONE);
  wire [1:0] reg_field = reg_code[1:0];
  wire [31:0] rd_word = (reg_code == CODE_CH10_CTL1) ? 32'(ch10_ctl1) :
                        reg_code[3] ? REG_RESET :
                        (reg_field == CODE_SRC[1:0]) ? src_reg[reg_code[2]] :
                        (reg_field == CODE_DST[1:0]) ? dst_reg[reg_code[2]] :
                        (reg_field == CODE_CTL0[1:0]) ? 32'(ctl0[reg_code[2]]) :
                        32'(ctl1[reg_code[2]]);

  // Engine view of the channel in service
  wire dcc_ctl0_s c0 = ctl0[cur];
  wire dcc_ctl1_s c1 = ctl1[cur];
  wire [31:0] cur_src = src_cur[cur];
  wire [31:0] cur_dst = dst_cur[cur];
  wire [16:0] cdone_n = done_bytes[cur] + BEAT_BYTES;
  wire [16:0] cseg_n = seg_bytes[cur] + BEAT_BYTES;
  wire [4:0] beats = burst_beats(c0.burst_code);
  wire [15:0] seg_size = seg_size_f(c0.transfer_length_bytes, c1.segment_order);
  wire last = cdone_n >= {1'b0, c0.transfer_length_bytes};
  wire seg_end = (cseg_n >= {1'b0, seg_size}) | last;
  wire burst_end = (beat + 5'h01) == beats;
  wire write_ack = (state == ST_WRITE) & mem_ack;
  wire [31:0] nsrc = c0.src_pointer_fixed ? cur_src : cur_src + BEAT_ADDR_STEP;
  wire [31:0] ndst = c1.coherent_flush_enable & last ? cur_dst :
                     c0.dst_pointer_fixed ? cur_dst : cur_dst + BEAT_ADDR_STEP;
  wire finish_ev = (write_ack & last & ~c1.coherent_flush_enable) | ((state == ST_FLUSH) & mem_ack);
  wire seg_ev = write_ack & seg_end;

  // Chain target among the channels held here
  wire [4:0] chain_sel = c1.chained_channel_select;
  wire [2:0] hold_clr;
  assign hold_clr[0] = finish_ev & (chain_sel == CH_NUM_10);
  assign hold_clr[1] = finish_ev & (chain_sel == CH_NUM_11);
  assign hold_clr[2] = finish_ev & (chain_sel == CH_NUM_12);
  wire target_hold = (chain_sel == CH_NUM_10) ? ch10_ctl1.channel_hold :
                     (chain_sel == CH_NUM_11) ? ctl1[0].channel_hold : ctl1[1].channel_hold;
  wire chain_fail = finish_ev & c1.chain_release_error_irq_enable & (|hold_clr) & ~target_hold;

  logic [NCH-1:0] eligible;
  logic [NCH-1:0] src_ok;
  logic [NCH-1:0] dst_ok;
  logic [NCH-1:0] wr_ch;
  logic [NCH-1:0] fin_ch;
  logic [NCH-1:0] seg_ch;
  logic [NCH-1:0] start_ch;

  // Fixed priority: the lower channel wins
  wire start_ev = (state == ST_IDLE) & (|eligible);
  wire pick = ~eligible[0];
  wire [31:0] start_src = fresh[pick] ? src_reg[pick] : src_cur[pick];

  for (genvar gc = 0; gc < NCH; gc++) begin : g_ch
    assign src_ok[gc] = line_ready(ctl1[gc].src_request_select, req_sync);
    assign dst_ok[gc] = line_ready(ctl1[gc].dst_request_select, req_sync);
    assign eligible[gc] = ctl0[gc].channel_run & ~ctl1[gc].channel_hold &
                          (ctl0[gc].software_trigger_mode | (src_ok[gc] & dst_ok[gc])) &
                          (ctl0[gc].transfer_length_bytes != 16'h0000);
    assign wr_ch[gc] = wr_en & ~reg_code[3] & (reg_code[2] == 1'(gc));
    assign fin_ch[gc] = finish_ev & (cur == 1'(gc));
    assign seg_ch[gc] = seg_ev & ~last & (cur == 1'(gc));
    assign start_ch[gc] = start_ev & (pick == 1'(gc)) & fresh[gc];

    always_comb begin
      next_ctl0[gc] = ctl0[gc];
      if (seg_ch[gc]) begin
        next_ctl0[gc].segment_index = ctl0[gc].segment_index + 8'h01;
      end
      if (start_ch[gc]) begin
        next_ctl0[gc].segment_index = 8'h00;
      end
      if (fin_ch[gc] & ~ctl1[gc].continuous_run_mode) begin
        next_ctl0[gc].channel_run = 1'b0;
      end
      if (wr_ch[gc] & (reg_field == CODE_CTL0[1:0])) begin
        next_ctl0[gc] = dcc_ctl0_s'((pwdata & CTL0_WMASK) | (32'(next_ctl0[gc]) & ~CTL0_WMASK));
      end
      next_ctl1[gc] = ctl1[gc];
      if (hold_clr[gc+1]) begin
        next_ctl1[gc].channel_hold = 1'b0;
      end
      if (wr_ch[gc] & (reg_field == CODE_CTL1[1:0])) begin
        next_ctl1[gc] = dcc_ctl1_s'(pwdata & CTL1_WMASK);
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        src_reg[gc] <= REG_RESET;
        dst_reg[gc] <= REG_RESET;
        ctl0[gc] <= dcc_ctl0_s'(REG_RESET);
        ctl1[gc] <= dcc_ctl1_s'(REG_RESET);
        segment_done_irq[gc] <= 1'b0;
        chain_error_irq[gc] <= 1'b0;
      end else begin
        if (wr_ch[gc] & (reg_field == CODE_SRC[1:0])) begin
          src_reg[gc] <= pwdata;
        end
        if (wr_ch[gc] & (reg_field == CODE_DST[1:0])) begin
          dst_reg[gc] <= pwdata;
        end
        ctl0[gc] <= next_ctl0[gc];
        ctl1[gc] <= next_ctl1[gc];
        segment_done_irq[gc] <= seg_ev & (cur == 1'(gc)) & c0.segment_irq_enable;
        chain_error_irq[gc] <= chain_fail & (cur == 1'(gc));
      end
    end
  end

  always_comb begin
    next_ch10_ctl1 = ch10_ctl1;
    if (hold_clr[0]) begin
      next_ch10_ctl1.channel_hold = 1'b0;
    end
    if (wr_en & (reg_code == CODE_CH10_CTL1)) begin
      next_ch10_ctl1 = dcc_ctl1_s'(pwdata & CTL1_WMASK);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ch10_ctl1 <= dcc_ctl1_s'(REG_RESET);
      req_meta <= 3'h0;
      req_sync <= 3'h0;
    end else begin
      ch10_ctl1 <= next_ch10_ctl1;
      req_meta <= {peripheral_request_two, peripheral_request_one, peripheral_request_zero};
      req_sync <= req_meta;
    end
  end

  // One wait state; read data registered on the same edge that raises pready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= REG_RESET;
      pslverr <= 1'b0;
    end else begin
      pready <= apb_setup_ok;
      prdata <= apb_setup_ok & ~pwrite ? rd_word : REG_RESET;
      pslverr <= apb_setup_ok & (reg_code == CODE_NONE);
    end
  end

  // Transfer engine; re-arbitrates after every burst
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
      cur <= 1'b0;
      beat <= 5'h00;
      mem_valid <= 1'b0;
      mem_req <= '0;
      fresh <= '1;
      for (int i = 0; i < NCH; i++) begin
        src_cur[i] <= REG_RESET;
        dst_cur[i] <= REG_RESET;
        done_bytes[i] <= 17'h00000;
        seg_bytes[i] <= 17'h00000;
      end
    end else begin
      case (state)
        ST_IDLE: begin
          if (start_ev) begin
            cur <= pick;
            beat <= 5'h00;
            if (fresh[pick]) begin
              src_cur[pick] <= src_reg[pick];
              dst_cur[pick] <= dst_reg[pick];
              done_bytes[pick] <= 17'h00000;
              seg_bytes[pick] <= 17'h00000;
              fresh[pick] <= 1'b0;
            end
            mem_valid <= 1'b1;
            mem_req <= '{write: 1'b0, addr: start_src, wdata: REG_RESET};
            state <= ST_READ;
          end
        end
        ST_READ: begin
          if (mem_ack) begin
            mem_req <= '{write: 1'b1, addr: cur_dst, wdata: mem_rdata};
            state <= ST_WRITE;
          end
        end
        ST_WRITE: begin
          if (mem_ack) begin
            src_cur[cur] <= nsrc;
            dst_cur[cur] <= ndst;
            done_bytes[cur] <= cdone_n;
            seg_bytes[cur] <= seg_end ? 17'h00000 : cseg_n;
            if (last & c1.coherent_flush_enable) begin
              mem_req <= '{write: 1'b0, addr: cur_dst, wdata: REG_RESET};
              state <= ST_FLUSH;
            end else if (last | burst_end) begin
              mem_valid <= 1'b0;
              state <= ST_IDLE;
            end else begin
              beat <= beat + 5'h01;
              mem_req <= '{write: 1'b0, addr: nsrc, wdata: REG_RESET};
              state <= ST_READ;
            end
          end
        end
        ST_FLUSH: begin
          if (mem_ack) begin
            mem_valid <= 1'b0;
            state <= ST_IDLE;
          end
        end
        default: begin
          mem_valid <= 1'b0;
          state <= ST_IDLE;
        end
      endcase
      // Reprogramming or completion restarts the next transfer from the top
      for (int i = 0; i < NCH; i++) begin
        if (wr_ch[i] | fin_ch[i]) begin
          fresh[i] <= 1'b1;
        end
      end
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_last_write;
    write_ack && last && c1.coherent_flush_enable;
  endsequence

  sequence s_flush_read;
    (state == ST_FLUSH) && !mem_req.write && mem_valid;
  endsequence

  run_clear_a: assert property ((fin_ch[0] && !ctl1[0].continuous_run_mode && !wr_ch[0])
    |=> !ctl0[0].channel_run) else $error("run not cleared at target");
  run_keep_a: assert property ((fin_ch[0] && ctl1[0].continuous_run_mode && !wr_ch[0])
    |=> (ctl0[0].channel_run == $past(ctl0[0].channel_run))) else $error("run changed in continuous mode");
  hold_block_a: assert property (start_ev |-> !ctl1[pick].channel_hold)
    else $error("held channel started");
  hw_wait_a: assert property ((start_ev && !ctl0[pick].software_trigger_mode)
    |-> (src_ok[pick] && dst_ok[pick])) else $error("hardware mode started without request");
  sw_go_a: assert property ((state == ST_IDLE && ctl0[0].software_trigger_mode && ctl0[0].channel_run
    && !ctl1[0].channel_hold && ctl0[0].transfer_length_bytes != 16'h0000) |=> (state == ST_READ))
    else $error("software mode did not start");
  seg_irq_a: assert property ((seg_ev && cur == 1'b0)
    |=> (segment_done_irq[0] == $past(ctl0[0].segment_irq_enable))) else $error("segment irq mismatch");
  src_fixed_a: assert property ((write_ack && !last && !burst_end && c0.src_pointer_fixed)
    |=> (mem_req.addr == $past(cur_src)) && !mem_req.write) else $error("fixed source moved");
  dst_step_a: assert property ((write_ack && !last && !c0.dst_pointer_fixed)
    |=> (cur_dst == $past(cur_dst) + BEAT_ADDR_STEP)) else $error("destination did not step");
  flush_read_a: assert property (s_last_write |=> s_flush_read ##0 (mem_req.addr == $past(cur_dst)))
    else $error("dummy read missing");
  burst_len_a: assert property ((state != ST_IDLE) |-> (beat < beats))
    else $error("burst overran");
  chain_clr_a: assert property ((hold_clr[1] && !wr_ch[0]) |=> !ctl1[0].channel_hold)
    else $error("chained hold not cleared");
  chain_err_a: assert property (chain_fail |=> $past(cur) ? chain_error_irq[1] : chain_error_irq[0])
    else $error("chain error irq missing");
  seg_restart_a: assert property (start_ch[0] |=> (ctl0[0].segment_index == 8'h00))
    else $error("segment index not restarted");

endmodule : dcc_channel_control

// [bench/dcc_mem_model.sv]
// Memory partner model: answers engine requests after a programmable wait
`timescale 1ns/1ps
module dcc_mem_model
  import dcc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic mem_valid,
  input wire dcc_mem_req_s mem_req,
  input wire logic [1:0] wait_cycles,
  output logic mem_ack,
  output logic [31:0] mem_rdata
);
  int wr_n;
  int rd_n;
  logic [31:0] last_wa;
  logic [31:0] last_wd;
  logic [31:0] last_ra;
  logic [1:0] cnt;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_ack <= 1'b0;
      mem_rdata <= 32'h00000000;
      cnt <= 2'h0;
      wr_n <= 0;
      rd_n <= 0;
    end else begin
      // Read data only meaningful in the ack cycle; otherwise it churns
      mem_rdata <= ~mem_rdata;
      if (mem_ack) begin
        mem_ack <= 1'b0;
        cnt <= 2'h0;
        if (mem_req.write) begin
          wr_n <= wr_n + 1;
          last_wa <= mem_req.addr;
          last_wd <= mem_req.wdata;
        end else begin
          rd_n <= rd_n + 1;
          last_ra <= mem_req.addr;
        end
      end else if (mem_valid) begin
        if (cnt >= wait_cycles) begin
          mem_ack <= 1'b1;
          mem_rdata <= mem_req.addr ^ 32'h5a5a0000;
        end else begin
          cnt <= cnt + 2'h1;
        end
      end
    end
  end
endmodule : dcc_mem_model

// [bench/testbench.sv]
// Register-level testbench for the DMA channel control block
`timescale 1ns/1ps
module testbench
  import dcc_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h00000000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [2:0] req_line = 3'h0;
  logic mem_valid;
  dcc_mem_req_s mem_req;
  logic mem_ack;
  logic [31:0] mem_rdata;
  logic [1:0] segment_done_irq;
  logic [1:0] chain_error_irq;
  logic [1:0] wait_cycles = 2'h0;
  int fail_count = 0;
  int cmp_count = 0;
  int seg_n[2] = '{0, 0};
  int err_n[2] = '{0, 0};
  int bursts = 0;
  logic valid_q = 1'b0;
  logic [31:0] r;
  logic e;
  int n;
  int s0;
  int b0;

  always #10 pclk = ~pclk;

  dcc_channel_control dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .peripheral_request_zero(req_line[0]), .peripheral_request_one(req_line[1]),
    .peripheral_request_two(req_line[2]), .mem_valid(mem_valid), .mem_req(mem_req), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .segment_done_irq(segment_done_irq), .chain_error_irq(chain_error_irq));

  dcc_mem_model mem (.pclk(pclk), .presetn(presetn), .mem_valid(mem_valid), .mem_req(mem_req),
    .wait_cycles(wait_cycles), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

  always @(posedge pclk) begin
    valid_q <= mem_valid;
    if (mem_valid === 1'b1 && valid_q === 1'b0) bursts <= bursts + 1;
    for (int i = 0; i < 2; i++) begin
      if (segment_done_irq[i] === 1'b1) seg_n[i] <= seg_n[i] + 1;
      if (chain_error_irq[i] === 1'b1) err_n[i] <= err_n[i] + 1;
    end
  end

  function automatic logic [31:0] c0(input logic [15:0] len, input logic sf, df, input logic [2:0] b,
    input logic ie, run, sw);
    return {len, 8'h00, sf, df, b, ie, run, sw};
  endfunction : c0

  function automatic logic [31:0] c1(input logic [3:0] nseg, input logic [5:0] ss, input logic ct,
    input logic [5:0] ds, input logic [4:0] ch, input logic coh, ee, hd);
    return {6'h00, nseg, ss, 1'b0, ct, ds, ch, coh, ee, hd};
  endfunction : c1

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      $display("BAD %0t: got %h expected %h", $time, seen, exp);
      fail_count++;
    end
  endtask : chk

  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] rd,
    output logic er);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (i >= 20) begin
      fail_count++;
      give_verdict();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic er;
    xfer(1'b1, a, d, rd, er);
  endtask : wr

  task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    logic er;
    xfer(1'b0, a, 32'h00000000, rd, er);
    chk(rd, exp);
  endtask : rdc

  // Waits for a write count, then for the engine to fall idle
  task automatic wait_wr(input int target);
    int i;
    for (i = 0; i < 3000; i++) begin
      @(posedge pclk);
      if (mem.wr_n >= target && mem_valid === 1'b0) break;
    end
    if (i >= 3000) begin
      fail_count++;
      give_verdict();
    end
    repeat (3) @(posedge pclk);
  endtask : wait_wr

  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rdc(CH10_CTL1_ADDR, REG_RESET);
    for (int a = 0; a < 8; a++) rdc(CH11_SRC_ADDR + 32'(4 * a), REG_RESET);
    xfer(1'b0, 32'h100028d0, 32'h00000000, r, e);
    chk({31'h0, e}, 32'h00000001);
    wr(CH11_CTL0_ADDR, 32'hfffffffd);
    rdc(CH11_CTL0_ADDR, 32'hfffffffd & CTL0_WMASK);
    wr(CH11_CTL1_ADDR, 32'hfffffffe);
    rdc(CH11_CTL1_ADDR, 32'hfffffffe & CTL1_WMASK);
    // Two words, coherent flush, single segment
    wr(CH11_SRC_ADDR, 32'h00001000);
    wr(CH11_DST_ADDR, 32'h00002000);
    wr(CH11_CTL1_ADDR, c1(4'h0, MEM_SELECT, 1'b0, MEM_SELECT, CH_NUM_11, 1'b1, 1'b0, 1'b0));
    s0 = seg_n[0];
    wr(CH11_CTL0_ADDR, c0(16'h0008, 1'b0, 1'b0, 3'h1, 1'b1, 1'b1, 1'b1));
    wait_wr(2);
    chk(mem.last_wa, 32'h00002004);
    chk(mem.last_wd, 32'h00001004 ^ 32'h5a5a0000);
    chk(32'(mem.rd_n), 32'h00000003);
    chk(mem.last_ra, 32'h00002004);
    chk(32'(seg_n[0] - s0), 32'h00000001);
    rdc(CH11_CTL0_ADDR, c0(16'h0008, 1'b0, 1'b0, 3'h1, 1'b1, 1'b0, 1'b1));
    // Two segments of rounded-up size, fixed destination
    wait_cycles <= 2'h1;
    wr(CH11_DST_ADDR, 32'h00003000);
    wr(CH11_CTL1_ADDR, c1(4'h1, MEM_SELECT, 1'b0, MEM_SELECT, CH_NUM_11, 1'b0, 1'b0, 1'b0));
    s0 = seg_n[0];
    n = mem.wr_n;
    wr(CH11_CTL0_ADDR, c0(16'h0011, 1'b0, 1'b1, 3'h0, 1'b1, 1'b1, 1'b1));
    wait_wr(n + 5);
    chk(mem.last_wa, 32'h00003000);
    chk(mem.last_wd, 32'h00001010 ^ 32'h5a5a0000);
    chk(32'(seg_n[0] - s0), 32'h00000002);
    rdc(CH11_CTL0_ADDR, c0(16'h0011, 1'b0, 1'b1, 3'h0, 1'b1, 1'b0, 1'b1) | 32'h00000100);
    // Burst codes 0 to 4, fixed source, varying memory wait
    wr(CH11_SRC_ADDR, 32'h00004000);
    wr(CH11_DST_ADDR, 32'h00005000);
    wr(CH11_CTL1_ADDR, c1(4'h0, MEM_SELECT, 1'b0, MEM_SELECT, CH_NUM_11, 1'b0, 1'b0, 1'b0));
    for (int b = 0; b <= 4; b++) begin
      wait_cycles <= 2'(b);
      n = mem.wr_n;
      b0 = bursts;
      s0 = seg_n[0];
      wr(CH11_CTL0_ADDR, c0(16'h0040, 1'b1, 1'b0, 3'(b), 1'b0, 1'b1, 1'b1));
      wait_wr(n + 16);
      chk(32'(bursts - b0), 32'(16 >> b));
      chk(mem.last_wa, 32'h0000503c);
      chk(mem.last_wd, 32'h00004000 ^ 32'h5a5a0000);
      chk(32'(seg_n[0] - s0), 32'h00000000);
      rdc(CH11_CTL0_ADDR, c0(16'h0040, 1'b1, 1'b0, 3'(b), 1'b0, 1'b0, 1'b1));
    end
    // Hardware-mode channel held, then released by the chain
    wait_cycles <= 2'h0;
    wr(CH12_SRC_ADDR, 32'h00006000);
    wr(CH12_DST_ADDR, 32'h00007000);
    wr(CH12_CTL1_ADDR, c1(4'h0, 6'h01, 1'b0, MEM_SELECT, CH_NUM_12, 1'b0, 1'b0, 1'b1));
    n = mem.wr_n;
    req_line <= 3'h2;
    wr(CH12_CTL0_ADDR, c0(16'h0004, 1'b0, 1'b0, 3'h0, 1'b1, 1'b1, 1'b0));
    repeat (30) @(posedge pclk);
    chk(32'(mem.wr_n - n), 32'h00000000);
    req_line <= 3'h5;
    wr(CH11_CTL1_ADDR, c1(4'h0, MEM_SELECT, 1'b0, MEM_SELECT, CH_NUM_12, 1'b0, 1'b1, 1'b0));
    wr(CH11_CTL0_ADDR, c0(16'h0004, 1'b0, 1'b0, 3'h0, 1'b0, 1'b1, 1'b1));
    wait_wr(n + 1);
    rdc(CH12_CTL1_ADDR, c1(4'h0, 6'h01, 1'b0, MEM_SELECT, CH_NUM_12, 1'b0, 1'b0, 1'b0));
    chk(32'(err_n[0]), 32'h00000000);
    repeat (30) @(posedge pclk);
    chk(32'(mem.wr_n - n), 32'h00000001);
    req_line <= 3'h2;
    wait_wr(n + 2);
    chk(mem.last_wa, 32'h00007000);
    chk(32'(seg_n[1]), 32'h00000001);
    wr(CH11_CTL0_ADDR, c0(16'h0004, 1'b0, 1'b0, 3'h0, 1'b0, 1'b1, 1'b1));
    wait_wr(n + 3);
    chk(32'(err_n[0]), 32'h00000001);
    chk(32'(err_n[1]), 32'h00000000);
    // Continuous mode keeps the channel running
    wr(CH11_CTL1_ADDR, c1(4'h0, MEM_SELECT, 1'b1, MEM_SELECT, CH_NUM_11, 1'b0, 1'b0, 1'b0));
    n = mem.wr_n;
    wr(CH11_CTL0_ADDR, c0(16'h0004, 1'b0, 1'b0, 3'h0, 1'b0, 1'b1, 1'b1));
    for (int i = 0; i < 200 && mem.wr_n < n + 3; i++) @(posedge pclk);
    if (mem.wr_n < n + 3) begin
      fail_count++;
      give_verdict();
    end
    rdc(CH11_CTL0_ADDR, c0(16'h0004, 1'b0, 1'b0, 3'h0, 1'b0, 1'b1, 1'b1));
    wr(CH11_CTL0_ADDR, c0(16'h0004, 1'b0, 1'b0, 3'h0, 1'b0, 1'b0, 1'b1));
    repeat (20) @(posedge pclk);
    n = mem.wr_n;
    repeat (30) @(posedge pclk);
    chk(32'(mem.wr_n - n), 32'h00000000);
    give_verdict();
  end
endmodule : testbench
